// file: pkg/fsq_pkg.sv
// shared constants and types for the flyback startup and fault sequencer
package fsq_pkg;
  // clock rate
  localparam int unsigned CLK_MHZ = 50;
  // wake-up ringing qualification time (ns), least time
  localparam int unsigned WAKE_QUAL_NS = 2000;
  localparam int unsigned WAKE_QUAL_CYC = (WAKE_QUAL_NS * CLK_MHZ + 999) / 1000;
  // first-cycle sense timeout (ns), longest time
  localparam int unsigned SENSE_TMO_NS = 4000;
  localparam int unsigned SENSE_TMO_CYC = (SENSE_TMO_NS * CLK_MHZ) / 1000;
  // leading-edge blanking (ns), least time
  localparam int unsigned BLANK_NS = 240;
  localparam int unsigned BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
  // high-frequency burst period after wake-up (ns)
  localparam int unsigned BURST_PER_NS = 12000;
  localparam int unsigned BURST_PER_CYC = (BURST_PER_NS * CLK_MHZ) / 1000;
  // maximum on-time cap (ns)
  localparam int unsigned MAX_ON_NS = 20000;
  localparam int unsigned MAX_ON_CYC = (MAX_ON_NS * CLK_MHZ) / 1000;
  localparam int unsigned CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  // cycle counts
  localparam logic [2:0] MIN_PEAK_CYCLES = 3'h4;
  localparam logic [1:0] FAULT_REPEAT = 2'h3;
  localparam logic [2:0] BURST_CYCLES = 3'h4;
  // valley count width
  localparam int unsigned VAL_W = 4;
  // peak level select encoding
  typedef enum logic [1:0] {
    PK_MIN = 2'h0,
    PK_START = 2'h1,
    PK_MAX = 2'h2
  } fsq_peak_t;
  // synchronised comparator decisions
  typedef struct packed {
    logic supply_on;      // supply above lockout turn-on
    logic supply_off;     // supply below lockout turn-off
    logic wake_low;       // sense above wake_threshold_low
    logic wake_high;      // sense above wake_threshold_high
    logic fb_below_lo;    // sample below lower startup level
    logic fb_above_hi;    // sample above upper startup level
    logic fb_ovp;         // sample above overvoltage level
    logic fb_lost;        // no feedback information
    logic line_run;       // line current above run level
    logic line_stop;      // line current below stop level
    logic cs_peak;        // sense current at selected peak
    logic cs_min;         // sense at sense_min_threshold
    logic cs_ocp;         // sense at overcurrent level
    logic valley;         // drain valley detected
    logic hot;            // overtemperature
  } fsq_cmp_t;
  typedef struct packed {
    logic gate;
    fsq_peak_t peak_sel;
    logic cc_demag_startup;
    logic startup_src_en;
    logic fault_bias;
    logic wait_bias;
  } fsq_drv_t;
endpackage

// file: verilog/fsq_sequencer.sv
// flyback startup, valley switching and fault sequencer
`timescale 1ns/100ps
module fsq_sequencer (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire fsq_pkg::fsq_cmp_t cmp_i,
  input wire logic [fsq_pkg::VAL_W-1:0] valley_target_i,
  input wire logic light_load_i,
  input wire logic in_regulation_i,
  output fsq_pkg::fsq_drv_t drv_o,
  output logic cc_mode_o,
  output logic startup_mode_o,
  output logic fault_o,
  output logic running_o
);
  import fsq_pkg::*;

  // wait is the light-load sleep between cycles; fault drains the supply to lockout
  typedef enum logic [2:0] {
    ST_OFF, ST_ON, ST_OFFTIME, ST_WAIT, ST_FAULT
  } fsq_state_t;

  // synchroniser stages; only the second stage is read by the sequencer logic
  fsq_cmp_t cmp_meta_reg;
  fsq_cmp_t cmp_reg;
  logic valley_d_reg;
  fsq_state_t state_reg;
  // one timer serves on-time and off-time, which never overlap
  logic [CNT_W-1:0] tmr_reg;
  logic [CNT_W-1:0] qual_reg;
  logic [VAL_W-1:0] val_cnt_reg;
  logic [2:0] first_cnt_reg;
  logic [2:0] burst_reg;
  // consecutive-cycle fault counters, saturating at the fault count
  logic [1:0] ovp_cnt_reg;
  logic [1:0] ocp_cnt_reg;
  logic [1:0] open_cnt_reg;
  logic startup_reg;
  logic line_ok_reg;
  logic first_cyc_reg;
  logic seen_min_reg;
  logic seen_ocp_reg;
  logic cs_high_reg;
  logic fault_reg;
  // decisions of the current cycle, read by several processes
  logic wake_ok;
  logic valley_edge;
  logic on_end;
  logic cycle_end;
  logic fault_now;

  // two-flop synchronisers on every comparator decision
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmp_meta_reg <= '0;
      cmp_reg <= '0;
      valley_d_reg <= 1'b0;
    end else begin
      cmp_meta_reg <= cmp_i;
      cmp_reg <= cmp_meta_reg;
      valley_d_reg <= cmp_reg.valley;
    end
  end

  assign valley_edge = cmp_reg.valley && !valley_d_reg;

  // ringing quiet timer, wait state only: restarts when sense is above low threshold, unless already qualified
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      qual_reg <= CNT_ZERO;
    end else if (state_reg != ST_WAIT || cmp_reg.wake_low) begin
      qual_reg <= (state_reg == ST_WAIT && qual_reg == WAKE_QUAL_CYC[CNT_W-1:0])
                  ? qual_reg : CNT_ZERO;
    end else if (qual_reg != WAKE_QUAL_CYC[CNT_W-1:0]) begin
      qual_reg <= qual_reg + CNT_ONE;
    end
  end

  // low wake needs quiet period first; strong wake skips it
  assign wake_ok = (cmp_reg.wake_low && qual_reg == WAKE_QUAL_CYC[CNT_W-1:0])
                   || cmp_reg.wake_high;

  // on-time ends at peak, after blanking; cap as safety
  assign on_end = state_reg == ST_ON && tmr_reg >= BLANK_CYC[CNT_W-1:0] &&
                  (cmp_reg.cs_peak || tmr_reg == MAX_ON_CYC[CNT_W-1:0]);
  assign cycle_end = on_end;

  // fault decision, evaluated at each on-time end or at once for async ones
  always_comb begin
    fault_now = 1'b0;
    if (state_reg != ST_OFF && state_reg != ST_FAULT) begin
      if (cmp_reg.hot) fault_now = 1'b1;
      if (cmp_reg.fb_lost) fault_now = 1'b1;
      if (!line_ok_reg) fault_now = 1'b1;
      // shorted pin: minimum level never seen within the first-cycle timeout
      if (first_cyc_reg && state_reg == ST_ON && !seen_min_reg &&
          tmr_reg == SENSE_TMO_CYC[CNT_W-1:0]) fault_now = 1'b1;
      if (cycle_end) begin
        if (cmp_reg.fb_ovp && ovp_cnt_reg == FAULT_REPEAT - 2'h1) fault_now = 1'b1;
        if ((seen_ocp_reg || cmp_reg.cs_ocp) && !cs_high_reg &&
            ocp_cnt_reg == FAULT_REPEAT - 2'h1) fault_now = 1'b1;
        if (cs_high_reg && open_cnt_reg == FAULT_REPEAT - 2'h1) fault_now = 1'b1;
      end
    end
  end

  // main sequencer
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_OFF;
      tmr_reg <= CNT_ZERO;
      val_cnt_reg <= '0;
      burst_reg <= 3'h0;
    end else if (cmp_reg.supply_off || fault_now) begin
      // any fault or lockout stops switching at once
      state_reg <= (fault_now && !cmp_reg.supply_off) ? ST_FAULT : ST_OFF;
      tmr_reg <= CNT_ZERO;
      burst_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        ST_OFF: begin
          if (cmp_reg.supply_on && cmp_reg.line_run) begin
            state_reg <= ST_ON;
            tmr_reg <= CNT_ZERO;
          end
        end
        ST_ON: begin
          tmr_reg <= tmr_reg + CNT_ONE;
          if (on_end) begin
            tmr_reg <= CNT_ZERO;
            val_cnt_reg <= '0;
            state_reg <= (light_load_i && burst_reg == 3'h0) ? ST_WAIT : ST_OFFTIME;
            if (burst_reg != 3'h0) burst_reg <= burst_reg - 3'h1;
          end
        end
        ST_OFFTIME: begin
          tmr_reg <= tmr_reg + CNT_ONE;
          // burst spacing caps the off-time so the wake response stays fast
          if (burst_reg != 3'h0 && tmr_reg >= BURST_PER_CYC[CNT_W-1:0]) begin
            state_reg <= ST_ON;
            tmr_reg <= CNT_ZERO;
          end else if (valley_edge) begin
            // period set by whole number of valleys skipped
            if (val_cnt_reg >= valley_target_i) begin
              state_reg <= ST_ON;
              tmr_reg <= CNT_ZERO;
            end else begin
              val_cnt_reg <= val_cnt_reg + {{(VAL_W-1){1'b0}}, 1'b1};
            end
            // ringing gone: turn on unsynchronised rather than stall
          end else if (tmr_reg == MAX_ON_CYC[CNT_W-1:0]) begin
            state_reg <= ST_ON;
            tmr_reg <= CNT_ZERO;
          end
        end
        ST_WAIT: begin
          if (wake_ok) begin
            state_reg <= ST_ON;
            tmr_reg <= CNT_ZERO;
            burst_reg <= BURST_CYCLES;
          end else if (!light_load_i) begin
            state_reg <= ST_OFFTIME;
            tmr_reg <= CNT_ZERO;
          end
        end
        ST_FAULT: begin
          // fault bias drains supply; lockout turn-off returns to start
          state_reg <= ST_FAULT;
        end
        default: state_reg <= ST_OFF;
      endcase
    end
  end

  // per-cycle observations for first-cycle and open/overcurrent checks
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen_min_reg <= 1'b0;
      seen_ocp_reg <= 1'b0;
      cs_high_reg <= 1'b0;
    end else if (state_reg != ST_ON) begin
      seen_min_reg <= 1'b0;
      seen_ocp_reg <= 1'b0;
      cs_high_reg <= 1'b0;
    end else begin
      if (cmp_reg.cs_min) seen_min_reg <= 1'b1;
      if (tmr_reg >= BLANK_CYC[CNT_W-1:0] && cmp_reg.cs_ocp) seen_ocp_reg <= 1'b1;
      // open pin sits at pull-up already during blanking
      if (tmr_reg == CNT_ZERO && cmp_reg.cs_ocp) cs_high_reg <= 1'b1;
    end
  end

  // saturating consecutive-cycle counters, cleared on a clean cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovp_cnt_reg <= 2'h0;
      ocp_cnt_reg <= 2'h0;
      open_cnt_reg <= 2'h0;
    end else if (state_reg == ST_OFF || state_reg == ST_FAULT) begin
      ovp_cnt_reg <= 2'h0;
      ocp_cnt_reg <= 2'h0;
      open_cnt_reg <= 2'h0;
    end else if (cycle_end) begin
      ovp_cnt_reg <= !cmp_reg.fb_ovp ? 2'h0 :
                     (ovp_cnt_reg == FAULT_REPEAT) ? ovp_cnt_reg : ovp_cnt_reg + 2'h1;
      ocp_cnt_reg <= !(seen_ocp_reg || cmp_reg.cs_ocp) ? 2'h0 :
                     (ocp_cnt_reg == FAULT_REPEAT) ? ocp_cnt_reg : ocp_cnt_reg + 2'h1;
      open_cnt_reg <= !cs_high_reg ? 2'h0 :
                      (open_cnt_reg == FAULT_REPEAT) ? open_cnt_reg : open_cnt_reg + 2'h1;
    end
  end

  // startup peak limiting and startup mode
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_cnt_reg <= 3'h0;
      first_cyc_reg <= 1'b1;
      startup_reg <= 1'b0;
    end else if (state_reg == ST_OFF || state_reg == ST_FAULT) begin
      first_cnt_reg <= 3'h0;
      first_cyc_reg <= 1'b1;
      startup_reg <= 1'b0;
    end else if (cycle_end) begin
      first_cyc_reg <= 1'b0;
      if (first_cnt_reg != MIN_PEAK_CYCLES) begin
        first_cnt_reg <= first_cnt_reg + 3'h1;
        if (first_cnt_reg == MIN_PEAK_CYCLES - 3'h1 && cmp_reg.fb_below_lo)
          startup_reg <= 1'b1;
      end else if (startup_reg && cmp_reg.fb_above_hi) begin
        startup_reg <= 1'b0;
      end
    end
  end

  // line monitor: sampled during on-time, hysteresis between run and stop
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_ok_reg <= 1'b0;
    end else if (state_reg == ST_OFF) begin
      line_ok_reg <= cmp_reg.line_run;
    end else if (state_reg == ST_ON && tmr_reg >= BLANK_CYC[CNT_W-1:0]) begin
      if (cmp_reg.line_stop) line_ok_reg <= 1'b0;
      else if (cmp_reg.line_run) line_ok_reg <= 1'b1;
    end
  end

  // fault indication held until lockout turn-off clears it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_reg <= 1'b0;
    end else if (fault_now) begin
      fault_reg <= 1'b1;
    end else if (cmp_reg.supply_off) begin
      fault_reg <= 1'b0;
    end
  end

  // registered drive outputs
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drv_o <= '{gate: 1'b0, peak_sel: PK_MIN, cc_demag_startup: 1'b0,
                 startup_src_en: 1'b1, fault_bias: 1'b0, wait_bias: 1'b0};
      cc_mode_o <= 1'b0;
      running_o <= 1'b0;
    end else begin
      // gate drops on the very edge that decides to stop, so no extra pulse leaks out
      drv_o.gate <= state_reg == ST_ON && !on_end && !fault_now && !cmp_reg.supply_off;
      drv_o.peak_sel <= (first_cnt_reg != MIN_PEAK_CYCLES) ? PK_MIN :
                        startup_reg ? PK_START : PK_MAX;
      drv_o.cc_demag_startup <= startup_reg;
      drv_o.startup_src_en <= state_reg == ST_OFF;
      drv_o.fault_bias <= state_reg == ST_FAULT;
      drv_o.wait_bias <= state_reg == ST_WAIT;
      cc_mode_o <= state_reg != ST_OFF && state_reg != ST_FAULT && !in_regulation_i;
      running_o <= state_reg != ST_OFF && state_reg != ST_FAULT;
    end
  end

  assign startup_mode_o = startup_reg;
  assign fault_o = fault_reg;
endmodule

// file: dv/fsq_sequencer_properties.sv
// port checker for the flyback sequencer, bound to its top module
`timescale 1ns/100ps
module fsq_sequencer_properties (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire fsq_pkg::fsq_cmp_t cmp_i,
  input wire fsq_pkg::fsq_drv_t drv_o,
  input wire logic cc_mode_o,
  input wire logic startup_mode_o,
  input wire logic fault_o,
  input wire logic running_o
);
  import fsq_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic [2:0] pulses_reg;
  // finished pulses since enable; cleared while stopped so each restart counts afresh
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulses_reg <= 3'h0;
    end else if (!running_o) begin
      pulses_reg <= 3'h0;
    end else if ($fell(drv_o.gate) && pulses_reg != 3'h7) begin
      pulses_reg <= pulses_reg + 3'h1;
    end
  end
  // sense seen at the peak level on two samples, well past blanking
  sequence peak_held;
    cmp_i.cs_peak [*2];
  endsequence
  fault_stops_gate_a: assert property (fault_o ##1 fault_o |-> !drv_o.gate)
    else $error("gate active during fault");
  fault_bias_on_a: assert property (fault_o ##1 fault_o |-> drv_o.fault_bias)
    else $error("fault bias missing");
  fault_held_a: assert property (fault_o && !cmp_i.supply_off && !$past(cmp_i.supply_off)
    && !$past(cmp_i.supply_off, 2) |=> fault_o) else $error("fault dropped early");
  source_off_a: assert property (drv_o.gate |-> !drv_o.startup_src_en)
    else $error("startup source on while switching");
  lockout_stop_a: assert property (cmp_i.supply_off [*6] |-> !drv_o.gate
    && drv_o.startup_src_en && !fault_o) else $error("lockout not obeyed");
  first_peaks_a: assert property (drv_o.gate && pulses_reg < 3'h4
    |-> drv_o.peak_sel == PK_MIN) else $error("early pulse above minimum peak");
  startup_peak_a: assert property (startup_mode_o && $stable(startup_mode_o) && drv_o.gate
    |-> drv_o.cc_demag_startup && drv_o.peak_sel == PK_START && pulses_reg >= 3'h4)
    else $error("startup mode drive wrong");
  normal_peak_a: assert property (!startup_mode_o && $stable(startup_mode_o) && drv_o.gate
    && pulses_reg >= 3'h4 |-> drv_o.peak_sel != PK_START && !drv_o.cc_demag_startup)
    else $error("startup drive outside startup mode");
  peak_ends_on_a: assert property ($rose(drv_o.gate) ##20 peak_held |-> ##[1:3] !drv_o.gate)
    else $error("on-time not ended at peak");
endmodule
bind fsq_sequencer fsq_sequencer_properties u_fsq_sequencer_properties (.mclk_i(mclk_i),
  .rst_n_i(rst_n_i), .cmp_i(cmp_i), .drv_o(drv_o), .cc_mode_o(cc_mode_o),
  .startup_mode_o(startup_mode_o), .fault_o(fault_o), .running_o(running_o));

// file: dv/fsq_power_stage.sv
// power stage model: primary current ramp on the sense pin and drain ringing
`timescale 1ns/100ps
module fsq_power_stage #(
  parameter int PEAK_CYC = 20
) (
  input wire logic mclk_i,
  input wire logic gate_i,
  input wire logic [1:0] sense_mode_i,
  output logic cs_peak_o,
  output logic cs_min_o,
  output logic cs_ocp_o,
  output logic valley_o
);
  logic [7:0] on_reg = 8'h00;
  logic [2:0] ring_reg = 3'h0;
  // on-time ramp counter and off-time ringing counter
  always_ff @(posedge mclk_i) begin
    if (!gate_i) begin
      on_reg <= 8'h00;
    end else if (on_reg != 8'hff) begin
      on_reg <= on_reg + 8'h01;
    end
    ring_reg <= gate_i ? 3'h0 : ring_reg + 3'h1;
  end
  // mode 1 is a shorted pin that never rises; mode 2 an open pin held at the pull-up
  // the open pin sits at the pull-up whether or not the switch conducts
  assign cs_min_o = sense_mode_i == 2'h2 ||
                    (gate_i && sense_mode_i == 2'h0 && on_reg >= 8'h03);
  assign cs_peak_o = sense_mode_i == 2'h2 ||
                     (gate_i && sense_mode_i == 2'h0 && on_reg >= 8'(PEAK_CYC));
  assign cs_ocp_o = sense_mode_i == 2'h2;
  // one valley per eight cycles of ringing, none while the switch conducts
  assign valley_o = !gate_i && ring_reg == 3'h7;
endmodule

// file: dv/tb.sv
// self-checking bench for the flyback startup and fault sequencer
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module tb;
  import fsq_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  fsq_cmp_t cmp_tb = '0;
  fsq_cmp_t cmp_i;
  fsq_drv_t drv_o;
  logic cc_mode_o, startup_mode_o, fault_o, running_o;
  logic regulated = 1'b0;
  logic light_load = 1'b0;
  logic [VAL_W-1:0] valley_target = 4'h0;
  logic [1:0] sense_mode = 2'h0;
  logic cs_peak, cs_min, cs_ocp, valley;
  int errors = 0;
  int check_count = 0;
  int k, n0, n2;
  always #10 mclk_i = ~mclk_i;
  // sense and valley bits come from the power stage model
  always_comb begin
    cmp_i = cmp_tb;
    cmp_i.cs_peak = cs_peak;
    cmp_i.cs_min = cs_min;
    cmp_i.cs_ocp = cs_ocp;
    cmp_i.valley = valley;
  end
  fsq_sequencer u_fsq_sequencer (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmp_i(cmp_i),
    .valley_target_i(valley_target), .light_load_i(light_load), .in_regulation_i(regulated),
    .drv_o(drv_o), .cc_mode_o(cc_mode_o), .startup_mode_o(startup_mode_o),
    .fault_o(fault_o), .running_o(running_o));
  fsq_power_stage u_fsq_power_stage (.mclk_i(mclk_i), .gate_i(drv_o.gate),
    .sense_mode_i(sense_mode), .cs_peak_o(cs_peak), .cs_min_o(cs_min),
    .cs_ocp_o(cs_ocp), .valley_o(valley));
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // bounded waits so a stuck design shows up as a mismatch
  task automatic wait_gate(input logic lvl);
    int n;
    n = 0;
    while (drv_o.gate !== lvl && n < 3000) begin
      tick(1);
      n++;
    end
    `CHK(drv_o.gate, lvl)
  endtask
  task automatic wait_fault();
    int n;
    n = 0;
    while (fault_o !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    `CHK(fault_o, 1'b1)
  endtask
  // off-time in clock cycles, from a gate fall to the next rise
  task automatic off_time(output int n);
    wait_gate(1'b0);
    n = 0;
    while (drv_o.gate !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
  endtask
  // lockout cycle then supply and line above their run levels
  task automatic power_up();
    cmp_tb.supply_on = 1'b0;
    cmp_tb.supply_off = 1'b1;
    tick(8);
    `CHK(drv_o.startup_src_en, 1'b1)
    `CHK(fault_o, 1'b0)
    cmp_tb.supply_off = 1'b0;
    cmp_tb.supply_on = 1'b1;
    cmp_tb.line_run = 1'b1;
  endtask
  task automatic results();
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    #1;
    `CHK(drv_o.gate, 1'b0)
    `CHK(drv_o.startup_src_en, 1'b1)
    rst_n_i = 1'b1;
    // low feedback: four minimum pulses, then startup mode
    cmp_tb.fb_below_lo = 1'b1;
    power_up();
    for (k = 0; k < 4; k++) begin
      wait_gate(1'b1);
      `CHK(drv_o.peak_sel, PK_MIN)
      `CHK(drv_o.startup_src_en, 1'b0)
      `CHK(running_o, 1'b1)
      wait_gate(1'b0);
    end
    wait_gate(1'b1);
    tick(2);
    `CHK(startup_mode_o, 1'b1)
    `CHK(drv_o.peak_sel, PK_START)
    `CHK(drv_o.cc_demag_startup, 1'b1)
    `CHK(cc_mode_o, 1'b1)
    cmp_tb.fb_below_lo = 1'b0;
    cmp_tb.fb_above_hi = 1'b1;
    for (k = 0; k < 2; k++) begin
      wait_gate(1'b0);
      wait_gate(1'b1);
    end
    tick(2);
    `CHK(startup_mode_o, 1'b0)
    `CHK(drv_o.peak_sel, PK_MAX)
    `CHK(drv_o.cc_demag_startup, 1'b0)
    regulated = 1'b1;
    wait_gate(1'b0);
    wait_gate(1'b1);
    tick(2);
    `CHK(cc_mode_o, 1'b0)
    // two more valleys skipped add two ringing periods of the model, 8 cycles each
    off_time(n0);
    valley_target = 4'h2;
    off_time(n2);
    `CHK(n2 - n0, 16)
    valley_target = 4'h0;
    // light load: wait state between cycles, left only on a qualified wake-up
    light_load = 1'b1;
    wait_gate(1'b0);
    tick(2);
    `CHK(drv_o.wait_bias, 1'b1)
    cmp_tb.wake_low = 1'b1;
    tick(150);
    `CHK(drv_o.gate, 1'b0)
    cmp_tb.wake_low = 1'b0;
    tick(int'(WAKE_QUAL_CYC) + 4);
    cmp_tb.wake_low = 1'b1;
    tick(6);
    `CHK(drv_o.gate, 1'b1)
    `CHK(drv_o.wait_bias, 1'b0)
    wait_gate(1'b0);
    tick(16);
    `CHK(drv_o.gate, 1'b1)
    // after the burst the wait returns; ringing still up, so only a strong wake-up counts
    tick(400);
    `CHK(drv_o.wait_bias, 1'b1)
    `CHK(drv_o.gate, 1'b0)
    cmp_tb.wake_high = 1'b1;
    tick(6);
    `CHK(drv_o.gate, 1'b1)
    light_load = 1'b0;
    cmp_tb.wake_low = 1'b0;
    cmp_tb.wake_high = 1'b0;
    // five fault kinds: overvoltage, heat, lost feedback, open pin, shorted pin
    for (k = 0; k < 5; k++) begin
      cmp_tb.fb_ovp = (k == 0);
      cmp_tb.hot = (k == 1);
      cmp_tb.fb_lost = (k == 2);
      sense_mode = (k == 3) ? 2'h2 : (k == 4) ? 2'h1 : 2'h0;
      power_up();
      if (k == 0 || k == 3) begin
        wait_gate(1'b1);
        wait_gate(1'b0);
        wait_gate(1'b1);
        wait_gate(1'b0);
        tick(4);
        `CHK(fault_o, 1'b0)
      end
      wait_fault();
      tick(2);
      `CHK(drv_o.gate, 1'b0)
      `CHK(drv_o.fault_bias, 1'b1)
      `CHK(running_o, 1'b0)
      if (k == 1) begin
        power_up();
        wait_fault();
      end
      cmp_tb = '0;
      sense_mode = 2'h0;
    end
    power_up();
    tick(4);
    results();
  end
  // watchdog sized well beyond the longest expected sequence
  initial begin
    #400000;
    errors++;
    results();
  end
endmodule
